//--- src/dmcs_sequencer.sv
/*
 Dust measuring cycle sequencer: APB registers, seconds timebase, cycle
 state machine, pulse counting and weather accumulation.
 Assumes pulse, clog and weather inputs are asynchronous pins and that the
 weather bus is stable around each one-second sample point.
*/
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "dmcs_cfg.svh"
module dmcs_sequencer import dmcs_pkg::*; #(
    parameter int TICKS_PER_S = `DMCS_CLK_HZ * `DMCS_TICK_S
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`DMCS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pulse_in,
    input wire logic clog_in,
    input wire logic [3:0] met_wind_dir,
    input wire logic [7:0] met_wind_speed,
    input wire logic [7:0] met_temp,
    input wire logic [7:0] met_hum,
    input wire logic [10:0] met_press,
    output logic pump_on,
    output logic head_rotate,
    output logic head_at_count
);
    dmcs_regs_t st_ff;
    dmcs_regs_t nxt_st;

    function automatic logic [16:0] period_s(input logic [2:0] z);
        case (z)
            3'h0: period_s = `DMCS_Z1_S;
            3'h1: period_s = `DMCS_Z2_S;
            3'h2: period_s = `DMCS_Z3_S;
            3'h3: period_s = `DMCS_Z4_S;
            3'h4: period_s = `DMCS_Z5_S;
            3'h5: period_s = `DMCS_Z6_S;
            default: period_s = `DMCS_Z7_S;
        endcase
    endfunction : period_s

    // Guarded divide, zero divisor yields zero
    function automatic logic [16:0] div17(input logic [16:0] a, input logic [16:0] b);
        div17 = (b == 17'h0) ? 17'h0 : a / b;
    endfunction : div17

    // Dead-time correction: n*t / (t - n*tau), saturates when the channel is swamped
    function automatic logic [31:0] dead_corr(input logic [23:0] n, input logic [8:0] t_s);
        logic [63:0] t_us;
        logic [63:0] loss;
        logic [63:0] q;
        t_us = {55'h0, t_s} * `DMCS_US_PER_S;
        loss = {40'h0, n} * `DMCS_DEAD_US;
        q = (loss >= t_us) ? 64'hFFFFFFFF : ({40'h0, n} * t_us) / (t_us - loss);
        dead_corr = (q > 64'hFFFFFFFF) ? 32'hFFFFFFFF : q[31:0];
    endfunction : dead_corr

    logic tick;
    logic pulse_ev;
    logic clog;
    logic ph_end;
    logic use_ref;
    logic setup_ph;
    logic wr_acc;
    logic [8:0] ph_len;
    logic [16:0] period;
    logic [16:0] tail;
    logic [16:0] interval;
    logic [2:0] zidx_next;
    dmcs_state_t nstate;
    logic [31:0] rd_mux;
    logic rd_bad;
    logic [16:0] avg;

    always_comb begin
        nxt_st = st_ff;
        nstate = st_ff.state;
        zidx_next = st_ff.zidx;
        avg = 17'h0;
        nxt_st.pulse_sy = {st_ff.pulse_sy[1:0], pulse_in};
        nxt_st.clog_sy = {st_ff.clog_sy[0], clog_in};
        nxt_st.met1 = {met_wind_dir, met_wind_speed, met_temp, met_hum, met_press};
        nxt_st.met2 = st_ff.met1;
        pulse_ev = st_ff.pulse_sy[1] & ~st_ff.pulse_sy[2];
        clog = st_ff.clog_sy[1];
        tick = (st_ff.tick_cnt == 32'(TICKS_PER_S - 1));
        nxt_st.tick_cnt = tick ? 32'h0 : st_ff.tick_cnt + 32'h1;
        // [RULE1] [RULE18] [RULE19] period from subrange
        period = period_s(st_ff.zidx);
        // [RULE11] [RULE12] reference pair only above three hours
        use_ref = (st_ff.zidx <= `DMCS_ZIDX_REF_MAX);
        tail = 17'(`DMCS_DECAY_S + `DMCS_ROT_S + `DMCS_COUNT_S)
            + (use_ref ? 17'(`DMCS_REF_S) : 17'h0);
        // [RULE14] interval that spreads samples over the cycle
        interval = period / 17'd100;
        case (st_ff.state)
            S_PRECOND: ph_len = `DMCS_PRECOND_S;
            S_DECAY, S_DECAY2: ph_len = `DMCS_DECAY_S;
            S_CNT_CLEAN, S_CNT_DUST: ph_len = `DMCS_COUNT_S;
            S_CNT_REF2: ph_len = `DMCS_REF_S;
            default: ph_len = `DMCS_ROT_S;
        endcase
        ph_end = tick && (st_ff.ph_cnt == ph_len - 9'h1);
        if (tick) begin
            nxt_st.ph_cnt = st_ff.ph_cnt + 9'h1;
        end
        if (st_ff.state != S_IDLE && st_ff.state != S_PRECOND && st_ff.state != S_FINISH) begin
            if (tick) begin
                nxt_st.sec_cnt = st_ff.sec_cnt + 17'h1;
                nxt_st.iv_cnt = (17'(st_ff.iv_cnt) == interval - 17'h1) ? 10'h0
                    : st_ff.iv_cnt + 10'h1;
                // [RULE14] one weather sample per interval, 100 at most
                if (st_ff.iv_cnt == 10'h0 && st_ff.samp_cnt < `DMCS_SAMPLES) begin
                    nxt_st.samp_cnt = st_ff.samp_cnt + 7'h1;
                    nxt_st.t_sum = st_ff.t_sum + 17'(st_ff.met2[26:19]);
                    nxt_st.h_sum = st_ff.h_sum + 17'(st_ff.met2[18:11]);
                    nxt_st.p_sum = st_ff.p_sum + 17'(st_ff.met2[10:0]);
                    nxt_st.w_cnt[st_ff.met2[38:35]] = st_ff.w_cnt[st_ff.met2[38:35]] + 7'h1;
                    nxt_st.w_sum[st_ff.met2[38:35]] = st_ff.w_sum[st_ff.met2[38:35]]
                        + 15'(st_ff.met2[34:27]);
                end
            end
        end
        case (st_ff.state)
            S_IDLE: ;
            S_PRECOND: begin
                // [RULE7] reference piece counted while the filter is conditioned
                if (pulse_ev) nxt_st.n_ref1 = st_ff.n_ref1 + 24'h1;
                // [RULE6] pump runs the full 300 s first
                if (ph_end) nstate = S_DECAY;
            end
            // [RULE10] underpressure decays before the head moves
            S_DECAY: if (ph_end) nstate = S_ROT_CNT;
            // [RULE9] fixed rotation slot
            S_ROT_CNT: if (ph_end) nstate = S_CNT_CLEAN;
            S_CNT_CLEAN: begin
                if (pulse_ev) nxt_st.n_clean = st_ff.n_clean + 24'h1;
                if (ph_end) nstate = S_ROT_SUCK;
            end
            S_ROT_SUCK: if (ph_end) nstate = S_PUMP;
            S_PUMP: begin
                // [RULE17] clogged filter cuts the deposition short
                if (clog) begin
                    nxt_st.clogged = 1'b1;
                    nstate = S_DECAY2;
                end else if (tick && st_ff.sec_cnt + 17'h1 + tail >= period) begin
                    nstate = S_DECAY2;
                end
            end
            S_DECAY2: if (ph_end) nstate = S_ROT_CNT2;
            S_ROT_CNT2: if (ph_end) nstate = S_CNT_DUST;
            S_CNT_DUST: begin
                if (pulse_ev) nxt_st.n_dust = st_ff.n_dust + 24'h1;
                // [RULE11] closing reference count on long cycles
                if (ph_end) nstate = use_ref ? S_CNT_REF2 : S_FINISH;
            end
            S_CNT_REF2: begin
                if (pulse_ev) nxt_st.n_ref2 = st_ff.n_ref2 + 24'h1;
                if (ph_end) nstate = S_FINISH;
            end
            S_FINISH: begin
                // [RULE15] direction share, per-direction speed, plain averages
                for (int i = 0; i < 16; i++) begin
                    nxt_st.w_pct[i] = 7'(div17(17'(st_ff.w_cnt[i]) * 17'd100,
                        17'(st_ff.samp_cnt)));
                    nxt_st.w_mean[i] = 8'(div17(17'(st_ff.w_sum[i]), 17'(st_ff.w_cnt[i])));
                end
                nxt_st.t_avg = 8'(div17(st_ff.t_sum, 17'(st_ff.samp_cnt)));
                nxt_st.h_avg = 8'(div17(st_ff.h_sum, 17'(st_ff.samp_cnt)));
                avg = div17(st_ff.p_sum, 17'(st_ff.samp_cnt));
                // [RULE16] pressure above 895 hPa, clamped into a byte
                if (avg <= `DMCS_PRESS_OFS) nxt_st.p_byte = 8'h00;
                else if (avg - `DMCS_PRESS_OFS > 17'd255) nxt_st.p_byte = 8'hFF;
                else nxt_st.p_byte = 8'(avg - `DMCS_PRESS_OFS);
                if (st_ff.mode == MODE_AUTO) begin
                    // [RULE3] [RULE19] heavy deposit or clog: one step shorter
                    if (st_ff.clogged || st_ff.mass > `DMCS_MASS_HI) begin
                        if (st_ff.zidx < `DMCS_ZIDX_MAX) zidx_next = st_ff.zidx + 3'h1;
                    // [RULE2] [RULE19] light deposit: one step longer
                    end else if (st_ff.mass < `DMCS_MASS_LO) begin
                        if (st_ff.zidx != 3'h0) zidx_next = st_ff.zidx - 3'h1;
                    end
                end
                // [RULE4] continuous mode leaves zidx_next untouched
                // [RULE5] single mode ends after this cycle
                if (st_ff.mode == MODE_SINGLE) nxt_st.running = 1'b0;
                nstate = S_IDLE;
            end
            default: nstate = S_IDLE;
        endcase
        setup_ph = psel && !penable;
        wr_acc = psel && penable && pwrite;
        if (wr_acc) begin
            case (paddr)
                `DMCS_REG_CTRL: begin
                    nxt_st.mode = (pwdata[1:0] == 2'h2) ? MODE_SINGLE
                        : (pwdata[1:0] == 2'h1) ? MODE_CONT : MODE_AUTO;
                    nxt_st.zidx_cfg = (pwdata[4:2] > `DMCS_ZIDX_MAX) ? `DMCS_ZIDX_MAX
                        : pwdata[4:2];
                    if (pwdata[`DMCS_CTRL_STOP]) begin
                        nxt_st.running = 1'b0;
                        nstate = S_IDLE;
                    end else if (pwdata[`DMCS_CTRL_START] && st_ff.state == S_IDLE) begin
                        nxt_st.running = 1'b1;
                        zidx_next = (pwdata[4:2] > `DMCS_ZIDX_MAX) ? `DMCS_ZIDX_MAX
                            : pwdata[4:2];
                    end
                end
                `DMCS_REG_MASS: nxt_st.mass = pwdata[15:0];
                `DMCS_REG_WIND: nxt_st.wind_sel = pwdata[3:0];
                default: ;
            endcase
        end
        nxt_st.zidx = zidx_next;
        // Next cycle starts from idle whenever still running
        if (nstate == S_IDLE && nxt_st.running && !(wr_acc && paddr == `DMCS_REG_CTRL
            && pwdata[`DMCS_CTRL_STOP])) begin
            // [RULE8] preconditioning on for one hour and longer
            nstate = (zidx_next <= `DMCS_ZIDX_PRECOND_MAX) ? S_PRECOND : S_ROT_CNT;
            nxt_st.sec_cnt = 17'h0;
            nxt_st.iv_cnt = 10'h0;
            nxt_st.samp_cnt = 7'h0;
            nxt_st.clogged = 1'b0;
            nxt_st.n_clean = 24'h0;
            nxt_st.n_dust = 24'h0;
            nxt_st.n_ref1 = 24'h0;
            nxt_st.n_ref2 = 24'h0;
            nxt_st.t_sum = 17'h0;
            nxt_st.h_sum = 17'h0;
            nxt_st.p_sum = 17'h0;
            nxt_st.w_cnt = '0;
            nxt_st.w_sum = '0;
        end
        if (nstate != st_ff.state) nxt_st.ph_cnt = 9'h0;
        nxt_st.state = nstate;
        rd_bad = 1'b0;
        case (paddr)
            `DMCS_REG_CTRL: rd_mux = {27'h0, st_ff.zidx_cfg, st_ff.mode};
            `DMCS_REG_STATUS: rd_mux = {21'h0, st_ff.zidx <= `DMCS_ZIDX_PRECOND_MAX,
                use_ref, st_ff.clogged, st_ff.running, st_ff.zidx, st_ff.state};
            `DMCS_REG_MASS: rd_mux = {16'h0, st_ff.mass};
            // [RULE13] counts read back dead-time corrected
            `DMCS_REG_N_CLEAN: rd_mux = dead_corr(st_ff.n_clean, `DMCS_COUNT_S);
            `DMCS_REG_N_DUST: rd_mux = dead_corr(st_ff.n_dust, `DMCS_COUNT_S);
            `DMCS_REG_N_REF1: rd_mux = dead_corr(st_ff.n_ref1, `DMCS_PRECOND_S);
            `DMCS_REG_N_REF2: rd_mux = dead_corr(st_ff.n_ref2, `DMCS_REF_S);
            `DMCS_REG_METEO: rd_mux = {8'h0, st_ff.p_byte, st_ff.h_avg, st_ff.t_avg};
            `DMCS_REG_WIND: rd_mux = {12'h0, st_ff.wind_sel, 1'b0,
                st_ff.w_pct[st_ff.wind_sel], st_ff.w_mean[st_ff.wind_sel]};
            default: begin
                rd_mux = 32'h0;
                rd_bad = 1'b1;
            end
        endcase
        // Read data is captured in setup so a zero-wait access returns it
        if (setup_ph) begin
            nxt_st.prdata = pwrite ? 32'h0 : rd_mux;
            nxt_st.pslverr = rd_bad;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pslverr = st_ff.pslverr;
    assign pready = 1'b1;
    assign pump_on = (st_ff.state == S_PRECOND) || (st_ff.state == S_PUMP);
    assign head_rotate = (st_ff.state == S_ROT_CNT) || (st_ff.state == S_ROT_SUCK)
        || (st_ff.state == S_ROT_CNT2);
    assign head_at_count = (st_ff.state == S_ROT_CNT) || (st_ff.state == S_CNT_CLEAN)
        || (st_ff.state == S_ROT_CNT2) || (st_ff.state == S_CNT_DUST)
        || (st_ff.state == S_CNT_REF2);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_precond_pump: assert property ( // [RULE6]
        st_ff.state == S_PRECOND && ph_end && !wr_acc |=> st_ff.state == S_DECAY
            && !pump_on && $past(st_ff.ph_cnt) == 9'd299)
        else $error("preconditioning did not last 300 s");
    a_precond_auto: assert property ( // [RULE8]
        $rose(st_ff.state == S_PRECOND) |-> st_ff.zidx <= 3'd5 && pump_on)
        else $error("preconditioning on a 30 min cycle");
    a_decay_quiet: assert property ( // [RULE10]
        $fell(pump_on) && st_ff.state != S_IDLE |-> st_ff.state inside {S_DECAY, S_DECAY2}
            && !head_rotate)
        else $error("head moved without decay wait");
    a_rot_slot: assert property ( // [RULE9]
        $fell(head_rotate) && st_ff.state != S_IDLE |-> $past(st_ff.ph_cnt) == 9'd9)
        else $error("rotation slot not 10 s");
    a_auto_longer: assert property ( // [RULE2]
        st_ff.state == S_FINISH && st_ff.mode == MODE_AUTO && !st_ff.clogged
            && st_ff.mass < 16'd100 && st_ff.zidx != 3'h0 && !wr_acc
        |=> st_ff.zidx == $past(st_ff.zidx) - 3'h1)
        else $error("auto mode did not lengthen");
    a_auto_shorter: assert property ( // [RULE3]
        st_ff.state == S_FINISH && st_ff.mode == MODE_AUTO && st_ff.mass > 16'd1600
            && st_ff.zidx < 3'd6 && !wr_acc |=> st_ff.zidx == $past(st_ff.zidx) + 3'h1)
        else $error("auto mode did not shorten");
    a_cont_fixed: assert property ( // [RULE4]
        st_ff.state == S_FINISH && st_ff.mode == MODE_CONT && !wr_acc
        |=> st_ff.zidx == $past(st_ff.zidx))
        else $error("continuous mode changed period");
    a_single_stop: assert property ( // [RULE5]
        st_ff.state == S_FINISH && st_ff.mode == MODE_SINGLE && !wr_acc
        |=> st_ff.state == S_IDLE ##1 st_ff.state == S_IDLE)
        else $error("single mode kept measuring");
    a_clog_end: assert property ( // [RULE17]
        st_ff.state == S_PUMP && clog && !wr_acc |=> st_ff.state == S_DECAY2 && st_ff.clogged)
        else $error("clog did not end deposition");
    a_sample_cap: assert property ( // [RULE14]
        st_ff.samp_cnt <= 7'd100)
        else $error("more than 100 weather samples");
endmodule : dmcs_sequencer

//--- src/dmcs_cfg.svh
/*
 Register offsets, field positions and timing figures of the
 dust measuring cycle sequencer. Assumes a 250 MHz APB clock.
*/
// What this block does
// [RULE1] Cycle period from seven programmable subranges
// [RULE2] Auto mode: mass under 100 lengthens next
// [RULE3] Auto mode: mass over 1600 shortens next
// [RULE4] Continuous mode keeps period unchanged
// [RULE5] Single mode runs one cycle, then stops
// [RULE6] Preconditioning runs pump 300 s first
// [RULE7] Reference piece counted during preconditioning
// [RULE8] Preconditioning automatic for subranges one to six
// [RULE9] Each head rotation gets a 10 s slot
// [RULE10] Wait 10 s after pump off before rotating
// [RULE11] Over three hours: reference counted start and end
// [RULE12] Reference ratio used only above three hours
// [RULE13] Counts corrected for 30 us dead time
// [RULE14] 100 weather samples evenly spread per cycle
// [RULE15] Wind direction percentages, per-direction speed, averages
// [RULE16] Pressure stored as reading minus 895, one byte
// [RULE17] Clogged filter ends the cycle early
// [RULE18] Subrange seven is the 30 minute cycle
// [RULE19] Subranges map 24h..30min, steps saturate
`ifndef DMCS_CFG_SVH
`define DMCS_CFG_SVH
`define DMCS_ADDR_W 8
`define DMCS_REG_CTRL 8'h00
`define DMCS_REG_STATUS 8'h04
`define DMCS_REG_MASS 8'h08
`define DMCS_REG_N_CLEAN 8'h0C
`define DMCS_REG_N_DUST 8'h10
`define DMCS_REG_N_REF1 8'h14
`define DMCS_REG_N_REF2 8'h18
`define DMCS_REG_METEO 8'h1C
`define DMCS_REG_WIND 8'h20
`define DMCS_CTRL_START 8
`define DMCS_CTRL_STOP 9
`define DMCS_CLK_HZ 250000000
`define DMCS_TICK_S 1
`define DMCS_PRECOND_S 9'd300
`define DMCS_DECAY_S 9'd10
`define DMCS_ROT_S 9'd10
`define DMCS_COUNT_S 9'd60
`define DMCS_REF_S 9'd60
`define DMCS_DEAD_US 64'd30
`define DMCS_US_PER_S 64'd1000000
`define DMCS_SAMPLES 7'd100
`define DMCS_MASS_LO 16'd100
`define DMCS_MASS_HI 16'd1600
`define DMCS_PRESS_OFS 17'd895
`define DMCS_ZIDX_MAX 3'd6
`define DMCS_ZIDX_PRECOND_MAX 3'd5
`define DMCS_ZIDX_REF_MAX 3'd2
`define DMCS_Z1_S 17'd86400
`define DMCS_Z2_S 17'd43200
`define DMCS_Z3_S 17'd21600
`define DMCS_Z4_S 17'd10800
`define DMCS_Z5_S 17'd7200
`define DMCS_Z6_S 17'd3600
`define DMCS_Z7_S 17'd1800
`endif

//--- src/dmcs_pkg.sv
/*
 Types of the dust measuring cycle sequencer: states, modes, state record.
 Assumes the constants header is included by the design file.
*/
package dmcs_pkg;
    typedef enum logic [3:0] {
        S_IDLE, S_PRECOND, S_DECAY, S_ROT_CNT, S_CNT_CLEAN, S_ROT_SUCK, S_PUMP,
        S_DECAY2, S_ROT_CNT2, S_CNT_DUST, S_CNT_REF2, S_FINISH
    } dmcs_state_t;

    typedef enum logic [1:0] {MODE_AUTO, MODE_CONT, MODE_SINGLE} dmcs_mode_t;

    typedef struct packed {
        dmcs_state_t state;
        dmcs_mode_t mode;
        logic [2:0] zidx_cfg;
        logic [2:0] zidx;
        logic running;
        logic clogged;
        logic [2:0] pulse_sy;
        logic [1:0] clog_sy;
        logic [38:0] met1;
        logic [38:0] met2;
        logic [31:0] tick_cnt;
        logic [16:0] sec_cnt;
        logic [8:0] ph_cnt;
        logic [9:0] iv_cnt;
        logic [6:0] samp_cnt;
        logic [23:0] n_clean;
        logic [23:0] n_dust;
        logic [23:0] n_ref1;
        logic [23:0] n_ref2;
        logic [15:0] mass;
        logic [3:0] wind_sel;
        logic [16:0] t_sum;
        logic [16:0] h_sum;
        logic [16:0] p_sum;
        logic [15:0][6:0] w_cnt;
        logic [15:0][14:0] w_sum;
        logic [7:0] t_avg;
        logic [7:0] h_avg;
        logic [7:0] p_byte;
        logic [15:0][6:0] w_pct;
        logic [15:0][7:0] w_mean;
        logic [31:0] prdata;
        logic pslverr;
    } dmcs_regs_t;
endpackage : dmcs_pkg

//--- dv/dmcs_far_side.sv
/*
 Far side of the sequencer: air pump, rotary head and radiation detector.
 Assumes pump and head outputs are plain levels in the pclk domain.
*/
`timescale 1ns/1ps
module dmcs_far_side (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pump_on,
    input wire logic head_rotate,
    input wire logic clog_req,
    output logic pulse_in,
    output logic clog_in,
    output logic [31:0] pump_len,
    output logic [31:0] rot_len,
    output logic [31:0] gap_len
);
    logic [2:0] div_ff;
    logic pump_ff;
    logic rot_ff;
    logic [31:0] run_ff;
    logic [31:0] turn_ff;
    logic [31:0] idle_ff;
    // Pulses 4 clocks wide so the input synchroniser never merges two
    assign pulse_in = div_ff[2];
    assign clog_in = clog_req;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 3'h0;
            {pump_ff, rot_ff} <= 2'h0;
            {run_ff, turn_ff, idle_ff} <= 96'h0;
            {pump_len, rot_len, gap_len} <= 96'h0;
        end else begin
            div_ff <= div_ff + 3'h1;
            pump_ff <= pump_on;
            rot_ff <= head_rotate;
            run_ff <= pump_on ? run_ff + 32'h1 : 32'h0;
            turn_ff <= head_rotate ? turn_ff + 32'h1 : 32'h0;
            idle_ff <= (pump_ff && !pump_on) ? 32'h1 : idle_ff + 32'h1;
            if (pump_ff && !pump_on) begin
                pump_len <= run_ff;
            end
            if (rot_ff && !head_rotate) begin
                rot_len <= turn_ff;
            end
            if (!rot_ff && head_rotate) begin
                gap_len <= idle_ff;
            end
        end
    end
endmodule : dmcs_far_side

//--- dv/dust_measuring_cycle_sequencer_tb.sv
/*
 Self-checking bench of the dust measuring cycle sequencer.
 Assumes the far-side model and a timebase of TPS clocks per second.
*/
`timescale 1ns/1ps
module dust_measuring_cycle_sequencer_tb import dmcs_pkg::*;;
    localparam int TPS = 2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic clog_req = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, pump_len, rot_len, gap_len;
    logic pready, pslverr, err_q, pulse_in, clog_in, pump_on, head_rotate, head_at_count;
    logic [2:0] zs [4] = '{3'h2, 3'h3, 3'h5, 3'h6};
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    initial begin
        forever #2 pclk = ~pclk;
    end
    dmcs_sequencer #(.TICKS_PER_S(TPS)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pulse_in(pulse_in), .clog_in(clog_in),
        .met_wind_dir(4'h3), .met_wind_speed(8'h30), .met_temp(8'h55), .met_hum(8'h22),
        .met_press(11'h3E8), .pump_on(pump_on), .head_rotate(head_rotate),
        .head_at_count(head_at_count));
    dmcs_far_side u_far (.pclk(pclk), .presetn(presetn), .pump_on(pump_on),
        .head_rotate(head_rotate), .clog_req(clog_req), .pulse_in(pulse_in),
        .clog_in(clog_in), .pump_len(pump_len), .rot_len(rot_len), .gap_len(gap_len));
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_near(input logic [31:0] got, input int exp, input int tol);
        checks_done++;
        if ((got <= 32'(exp + tol) && got + 32'(tol) >= 32'(exp)) !== 1'b1) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_near
    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Leaving a state skips FINISH: it lasts one clock and still shows the old subrange
    task automatic poll(input logic [3:0] s, input logic eq);
        do begin
            apb(1'b0, 8'h04, 32'h0);
        end while ((rd[3:0] === s) !== eq || (!eq && rd[3:0] === 4'(S_FINISH)));
    endtask : poll
    task automatic t_regs();
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h24, 32'h0);
        chk({31'h0, err_q}, 32'h1);
        apb(1'b1, 8'h00, 32'h1D);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h19);
        apb(1'b1, 8'h04, 32'hFFFF);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h600);
    endtask : t_regs
    task automatic t_flags(input logic [2:0] z);
        logic [3:0] s;
        s = (z == 3'h6) ? 4'(S_ROT_CNT) : 4'(S_PRECOND);
        apb(1'b1, 8'h00, {23'h0, 1'b1, 3'h0, z, 2'h0});
        apb(1'b0, 8'h04, 32'h0);
        chk({21'h0, rd[10:0]}, {21'h0, z <= 3'h5, z <= 3'h2, 2'h1, z, s});
        chk({31'h0, pump_on}, {31'h0, z <= 3'h5});
        chk({31'h0, head_at_count}, {31'h0, z == 3'h6});
        apb(1'b1, 8'h00, 32'h200);
    endtask : t_flags
    task automatic t_single();
        int t0;
        apb(1'b1, 8'h00, 32'h11A);
        t0 = cyc;
        poll(4'(S_IDLE), 1'b1);
        chk_near(cyc - t0, 1800 * TPS, 4 * TPS);
        chk_near(rot_len, 10 * TPS, 1);
        chk_near(gap_len, 10 * TPS, 1);
        apb(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'h00692255);
        apb(1'b1, 8'h20, 32'h3);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h00036430);
        repeat (50) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0);
        chk({28'h0, rd[3:0]}, 32'h0);
    endtask : t_single
    task automatic t_cycle(input logic [1:0] m, input logic [2:0] z, input logic [15:0] mass,
                           input logic [2:0] nz);
        apb(1'b1, 8'h00, {23'h0, 1'b1, 3'h0, z, m});
        if (z <= 3'h5) begin
            poll(4'(S_DECAY), 1'b1);
            chk_near(pump_len, 300 * TPS, TPS);
            apb(1'b0, 8'h14, 32'h0);
            chk({31'h0, rd != 32'h0}, 32'h1);
        end
        poll(4'(S_CNT_DUST), 1'b1);
        apb(1'b1, 8'h08, {16'h0, mass});
        poll(4'(S_CNT_DUST), 1'b0);
        chk({29'h0, rd[6:4]}, {29'h0, nz});
        apb(1'b1, 8'h00, 32'h200);
    endtask : t_cycle
    // Starts on subrange six so that the clog visibly shortens the next cycle
    task automatic t_clog();
        int t0;
        apb(1'b1, 8'h00, 32'h114);
        poll(4'(S_PUMP), 1'b1);
        t0 = cyc;
        clog_req <= 1'b1;
        poll(4'(S_PUMP), 1'b0);
        chk({31'h0, (cyc - t0) < 20}, 32'h1);
        chk({31'h0, rd[8]}, 32'h1);
        poll(4'(S_CNT_DUST), 1'b1);
        poll(4'(S_CNT_DUST), 1'b0);
        chk({29'h0, rd[6:4]}, 32'h6);
        apb(1'b1, 8'h00, 32'h200);
        clog_req <= 1'b0;
    endtask : t_clog
    // Full run needs about 24000 clocks
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        $display("test regs done");
        for (int i = 0; i < 4; i++) begin
            t_flags(zs[i]);
        end
        $display("test flags done");
        t_single();
        $display("test single done");
        t_cycle(2'h0, 3'h5, 16'd99, 3'h4);
        $display("test lengthen done");
        t_cycle(2'h0, 3'h5, 16'd1601, 3'h6);
        $display("test shorten done");
        t_cycle(2'h1, 3'h6, 16'd50, 3'h6);
        $display("test continuous done");
        t_clog();
        $display("test clog done");
        summarize();
    end
endmodule : dust_measuring_cycle_sequencer_tb
